// File: rtl/adc_pf_consts.svh
// register map, field positions, reset values and timing counts of the converter control
`ifndef ADC_PF_CONSTS_SVH
`define ADC_PF_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADC_ADDR_RESULT_LO   16'hff08
`define ADC_ADDR_RESULT_HI   16'hff09
`define ADC_ADDR_MODE        16'hff28
`define ADC_ADDR_CHAN        16'hff29
`define ADC_ADDR_PFM         16'hff2a
`define ADC_ADDR_PFT         16'hff2b

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADC_MODE_RUN_BIT     7
`define ADC_MODE_FT_HI       5
`define ADC_MODE_FT_LO       3
`define ADC_MODE_BOOST_BIT   0
`define ADC_PFM_EN_BIT       7
`define ADC_PFM_DIR_BIT      6
`define ADC_RES_PAD          6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADC_MODE_RST         8'h00
`define ADC_CHAN_RST         8'h00
`define ADC_PFM_RST          8'h00
`define ADC_PFT_RST          8'h00

// ----------------------------------------------------------------
// conversion timing, in system clock cycles per conversion
// ----------------------------------------------------------------
`define ADC_CYC_000          288
`define ADC_CYC_001          240
`define ADC_CYC_010          192
`define ADC_CYC_100          144
`define ADC_CYC_101          120
`define ADC_CYC_110          96
// each conversion is this many equal steps: two of sampling, one per result bit
`define ADC_STEPS            12
`define ADC_SAMPLE_STEPS     2

`endif

// File: rtl/adc_pf_pkg.sv
// types shared by the converter control and its register bus
package adc_pf_pkg;

	// ----------------------------------------------------------------
	// register bus request, held by the cpu until bus_ready
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        sel;
		logic        we;
		logic        word;
		logic        bit_op;
		logic [2:0]  bit_idx;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bus_req_t;

	// ----------------------------------------------------------------
	// sequencer phases and control state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_SAMPLE,
		PH_CONVERT
	} phase_t;

	typedef struct packed {
		logic        run;
		logic [2:0]  ftime;
		logic        boost;
		logic [1:0]  chan;
		logic        pf_en;
		logic        pf_dir;
		logic [7:0]  thr;
		logic [9:0]  result;
		phase_t      phase;
		logic [4:0]  sub;
		logic [3:0]  step_idx;
		logic [8:0]  conv_cyc;
		logic        irq;
		logic        wait_done;
		logic [15:0] rdata;
	} ctrl_state_t;

endpackage : adc_pf_pkg

// File: rtl/sar_core.sv
// successive approximation register, resolving one bit per decide strobe
`timescale 1ns/1ps
`default_nettype none

module sar_core #(
	parameter int W = 10
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic         start,
	input  wire logic         decide,
	input  wire logic         comp_high,
	output logic [W-1:0]      trial,
	output logic [W-1:0]      resolved
);

	typedef struct packed {
		logic [W-1:0] trial;
		logic [W-1:0] mask;
	} sar_state_t;

	sar_state_t q_r;
	sar_state_t q_nxt;

	// ----------------------------------------------------------------
	// bit decision
	// ----------------------------------------------------------------
	// the bit under test is kept when the input is at or above the tap
	assign resolved = comp_high ? q_r.trial : (q_r.trial & ~q_r.mask);
	assign trial    = q_r.trial;

	always_comb begin
		q_nxt = q_r;
		if (start) begin
			q_nxt.trial = {1'b1, {(W-1){1'b0}}};
			q_nxt.mask  = {1'b1, {(W-1){1'b0}}};
		end else if (decide) begin
			q_nxt.trial = resolved | (q_r.mask >> 1);
			q_nxt.mask  = q_r.mask >> 1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

endmodule : sar_core

`default_nettype wire

// File: rtl/adc_pf_ctrl.sv
// control of a four-channel 10-bit converter with power-fail comparison
`timescale 1ns/1ps
`default_nettype none
`include "adc_pf_consts.svh"

module adc_pf_ctrl #(
	parameter int CH_N = 4
) (
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire adc_pf_pkg::bus_req_t bus_req,
	output logic                      bus_ready,
	output logic [15:0]               bus_rdata,
	input  wire logic                 comp_high,
	output logic [9:0]                dac_code,
	output logic                      sample_hold_en,
	output logic [1:0]                analog_channel,
	output logic                      boost_ref_en,
	output logic [CH_N-1:0]           digital_input_en,
	output logic                      conversion_done_irq
);

	adc_pf_pkg::ctrl_state_t q_r;
	adc_pf_pkg::ctrl_state_t q_nxt;

	logic [4:0] step_len;
	logic       acc;
	logic       is_ctl;
	logic       needs_wait;
	logic       wr;
	logic       ctl_wr;
	logic       last_bit;
	logic       complete;
	logic       sar_start;
	logic       sar_decide;
	logic       pf_hit;
	logic [7:0] nv;
	logic [9:0] resolved;
	logic [9:0] trial;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// prohibited codes fall back to the slowest timing, which is the safe side
	function automatic logic [4:0] step_of(input logic [2:0] code);
		logic [8:0] cyc;
		case (code)
			3'b000: cyc = 9'(`ADC_CYC_000);
			3'b001: cyc = 9'(`ADC_CYC_001);
			3'b010: cyc = 9'(`ADC_CYC_010);
			3'b100: cyc = 9'(`ADC_CYC_100);
			3'b101: cyc = 9'(`ADC_CYC_101);
			3'b110: cyc = 9'(`ADC_CYC_110);
			default: cyc = 9'(`ADC_CYC_000);
		endcase
		return 5'(cyc / 9'(`ADC_STEPS));
	endfunction : step_of

	function automatic logic [7:0] merge(input logic [7:0] old, input adc_pf_pkg::bus_req_t r);
		logic [7:0] v;
		v = old;
		if (r.bit_op) begin
			v[r.bit_idx] = r.wdata[0];
		end else begin
			v = r.wdata;
		end
		return v;
	endfunction : merge

	function automatic logic [15:0] read_mux(input adc_pf_pkg::ctrl_state_t s, input adc_pf_pkg::bus_req_t r);
		logic [15:0] d;
		d = 16'h0000;
		case (r.addr)
			`ADC_ADDR_RESULT_LO: begin
				if (r.word) begin
					d = {s.result, {`ADC_RES_PAD{1'b0}}};
				end else begin
					d = {8'h00, s.result[1:0], {`ADC_RES_PAD{1'b0}}};
				end
			end
			`ADC_ADDR_RESULT_HI: d = {8'h00, s.result[9:2]};
			`ADC_ADDR_MODE:      d = {8'h00, s.run, 1'b0, s.ftime, 2'b00, s.boost};
			`ADC_ADDR_CHAN:      d = {8'h00, 6'b00_0000, s.chan};
			`ADC_ADDR_PFM:       d = {8'h00, s.pf_en, s.pf_dir, 6'b00_0000};
			`ADC_ADDR_PFT:       d = {8'h00, s.thr};
			default:             d = 16'h0000;
		endcase
		return d;
	endfunction : read_mux

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	assign acc    = bus_req.sel;
	assign is_ctl = (bus_req.addr == `ADC_ADDR_MODE) || (bus_req.addr == `ADC_ADDR_CHAN) ||
	                (bus_req.addr == `ADC_ADDR_PFM) || (bus_req.addr == `ADC_ADDR_PFT);
	// every read waits one cycle so the data can leave a flip-flop
	assign needs_wait = acc && (!bus_req.we || is_ctl);
	assign bus_ready  = acc && (!needs_wait || q_r.wait_done);
	assign wr         = bus_ready && bus_req.we;
	assign ctl_wr     = wr && is_ctl;

	assign step_len = step_of(q_r.ftime);
	assign last_bit = (q_r.phase != adc_pf_pkg::PH_IDLE) && (q_r.sub == step_len - 5'd1) &&
	                  (q_r.step_idx == 4'(`ADC_STEPS - 1));
	// a control write in the finishing cycle aborts that conversion too
	assign complete = last_bit && !ctl_wr;
	assign pf_hit   = q_r.pf_dir ? (resolved[9:2] < q_r.thr) : (resolved[9:2] >= q_r.thr);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		q_nxt      = q_r;
		nv         = 8'h00;
		sar_start  = 1'b0;
		sar_decide = 1'b0;
		q_nxt.irq       = 1'b0;
		q_nxt.wait_done = needs_wait && !q_r.wait_done;
		if (acc && !bus_req.we && !q_r.wait_done) begin
			q_nxt.rdata = read_mux(q_r, bus_req);
		end

		if (wr) begin
			case (bus_req.addr)
				`ADC_ADDR_MODE: begin
					nv = merge({q_r.run, 1'b0, q_r.ftime, 2'b00, q_r.boost}, bus_req);
					q_nxt.run   = nv[`ADC_MODE_RUN_BIT];
					q_nxt.ftime = nv[`ADC_MODE_FT_HI:`ADC_MODE_FT_LO];
					q_nxt.boost = nv[`ADC_MODE_BOOST_BIT];
				end
				`ADC_ADDR_CHAN: begin
					nv = merge({6'b00_0000, q_r.chan}, bus_req);
					q_nxt.chan = nv[1:0];
				end
				`ADC_ADDR_PFM: begin
					nv = merge({q_r.pf_en, q_r.pf_dir, 6'b00_0000}, bus_req);
					q_nxt.pf_en  = nv[`ADC_PFM_EN_BIT];
					q_nxt.pf_dir = nv[`ADC_PFM_DIR_BIT];
				end
				`ADC_ADDR_PFT: begin
					// the threshold takes byte writes only
					if (!bus_req.bit_op) begin
						q_nxt.thr = bus_req.wdata;
					end
				end
				default: begin
				end
			endcase
		end

		// conversion sequencer: two sampling steps, then one step per bit
		case (q_r.phase)
			adc_pf_pkg::PH_IDLE: begin
				if (q_r.run) begin
					q_nxt.phase    = adc_pf_pkg::PH_SAMPLE;
					q_nxt.sub      = 5'd0;
					q_nxt.step_idx = 4'd0;
					q_nxt.conv_cyc = 9'd0;
					sar_start      = 1'b1;
				end
			end
			adc_pf_pkg::PH_SAMPLE, adc_pf_pkg::PH_CONVERT: begin
				q_nxt.conv_cyc = q_r.conv_cyc + 9'd1;
				if (q_r.sub == step_len - 5'd1) begin
					q_nxt.sub = 5'd0;
					if (q_r.step_idx >= 4'(`ADC_SAMPLE_STEPS)) begin
						sar_decide = 1'b1;
					end
					if (q_r.step_idx == 4'(`ADC_STEPS - 1)) begin
						q_nxt.phase    = adc_pf_pkg::PH_SAMPLE;
						q_nxt.step_idx = 4'd0;
						q_nxt.conv_cyc = 9'd0;
						sar_start      = 1'b1;
					end else begin
						q_nxt.step_idx = q_r.step_idx + 4'd1;
						if (q_r.step_idx == 4'(`ADC_SAMPLE_STEPS - 1)) begin
							q_nxt.phase = adc_pf_pkg::PH_CONVERT;
						end
					end
				end else begin
					q_nxt.sub = q_r.sub + 5'd1;
				end
			end
			default: begin
				q_nxt.phase = adc_pf_pkg::PH_IDLE;
			end
		endcase

		// an aborted conversion leaves result and interrupt untouched
		if (complete) begin
			q_nxt.result = resolved;
			q_nxt.irq    = q_r.pf_en ? pf_hit : 1'b1;
		end

		// control writes restart from the beginning, or stop if run is now clear
		if (ctl_wr) begin
			q_nxt.phase    = q_nxt.run ? adc_pf_pkg::PH_SAMPLE : adc_pf_pkg::PH_IDLE;
			q_nxt.sub      = 5'd0;
			q_nxt.step_idx = 4'd0;
			q_nxt.conv_cyc = 9'd0;
			sar_start      = q_nxt.run;
			sar_decide     = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------------------------------
	// approximation register and outputs
	// ----------------------------------------------------------------
	sar_core #(
		.W (10)
	) u_sar (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.start     (sar_start),
		.decide    (sar_decide),
		.comp_high (comp_high),
		.trial     (trial),
		.resolved  (resolved)
	);

	assign dac_code            = trial;
	assign sample_hold_en      = (q_r.phase == adc_pf_pkg::PH_SAMPLE);
	assign analog_channel      = q_r.chan;
	assign boost_ref_en        = q_r.boost;
	assign conversion_done_irq = q_r.irq;
	assign bus_rdata           = q_r.rdata;

	// only the pin being converted is taken from the digital port
	generate
		for (genvar i = 0; i < CH_N; i++) begin : g_din
			assign digital_input_en[i] = !(q_r.run && (q_r.chan == 2'(i)));
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	normal_irq_a: assert property (complete && !q_r.pf_en |=> conversion_done_irq)
		else $error("normal conversion finished without interrupt");
	pf_block_a: assert property (complete && q_r.pf_en && !q_r.pf_dir && (resolved[9:2] < q_r.thr)
		|=> !conversion_done_irq)
		else $error("power-fail interrupt raised without match");
	pf_less_a: assert property (complete && q_r.pf_en && q_r.pf_dir && (resolved[9:2] < q_r.thr)
		|=> conversion_done_irq)
		else $error("power-fail below-threshold interrupt missing");
	result_load_a: assert property (complete |=> q_r.result == $past(resolved))
		else $error("result not loaded at conversion end");
	result_pad_a: assert property (bus_ready && !bus_req.we && bus_req.word &&
		bus_req.addr == `ADC_ADDR_RESULT_LO |-> bus_rdata[5:0] == 6'b00_0000 && bus_rdata[15:6] == $past(q_r.result))
		else $error("result word layout wrong");
	high_byte_a: assert property (bus_ready && !bus_req.we && bus_req.addr == `ADC_ADDR_RESULT_HI
		|-> bus_rdata[7:0] == $past(q_r.result[9:2]))
		else $error("result high byte wrong");
	ctl_wait_a: assert property (acc && bus_req.we && is_ctl && !q_r.wait_done |-> !bus_ready ##1 bus_ready)
		else $error("control write without one wait cycle");
	mode_reset_a: assert property (disable iff (1'b0) !rstn |=> q_r.run == 1'b0 && q_r.ftime == 3'b000 &&
		q_r.boost == 1'b0 && q_r.chan == 2'b00 && q_r.pf_en == 1'b0 && q_r.thr == 8'h00)
		else $error("control registers not cleared by reset");
	stop_now_a: assert property ($fell(q_r.run) |-> q_r.phase == adc_pf_pkg::PH_IDLE)
		else $error("conversion continued after run cleared");
	restart_a: assert property (ctl_wr && q_nxt.run |=> q_r.phase == adc_pf_pkg::PH_SAMPLE &&
		q_r.conv_cyc == 9'd0 && q_r.step_idx == 4'd0)
		else $error("control write did not restart conversion");
	conv_len_a: assert property (complete |-> q_r.conv_cyc == 9'(step_len) * 9'(`ADC_STEPS) - 9'd1)
		else $error("conversion length differs from selected time");
	back_to_back_a: assert property (complete |=> q_r.phase == adc_pf_pkg::PH_SAMPLE && q_r.conv_cyc == 9'd0)
		else $error("next conversion did not start at once");
	idle_quiet_a: assert property (!q_r.run && !q_r.boost |-> q_r.phase == adc_pf_pkg::PH_IDLE && !boost_ref_en)
		else $error("converter active with run and boost clear");
	din_mask_a: assert property (q_r.run |-> !digital_input_en[q_r.chan])
		else $error("converted pin left as digital input");

endmodule : adc_pf_ctrl

`default_nettype wire

// File: testbench/analog_front_model.sv
// behavioural analog comparator with one fixed level per input channel
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
	input  wire logic [3:0][9:0] level,
	input  wire logic [1:0]      analog_channel,
	input  wire logic [9:0]      dac_code,
	output logic                 comp_high
);
	// ----------------------------------------------------------------
	// comparator
	// ----------------------------------------------------------------
	// ideal comparator, no offset: a tap equal to the input reads as high
	assign comp_high = (level[analog_channel] >= dac_code);
endmodule : analog_front_model

`default_nettype wire

// File: testbench/sar_adc_power_fail_control_tb.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
`include "adc_pf_consts.svh"

module sar_adc_power_fail_control_tb;
	logic                 core_clk  = 1'b0;
	logic                 rstn      = 1'b0;
	adc_pf_pkg::bus_req_t bus_req   = '0;
	logic                 bus_ready;
	logic [15:0]          bus_rdata;
	logic                 comp_high;
	logic [9:0]           dac_code;
	logic                 sample_hold_en;
	logic [1:0]           analog_channel;
	logic                 boost_ref_en;
	logic [3:0]           digital_input_en;
	logic                 conversion_done_irq;
	logic [3:0][9:0]      level     = {10'h07e, 10'h3c3, 10'h155, 10'h2a5};
	logic [2:0]           codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
	int                   cyc [7]   = '{288, 240, 192, 144, 120, 96, 288};
	logic [15:0]          regs [4]  = '{`ADC_ADDR_MODE, `ADC_ADDR_CHAN, `ADC_ADDR_PFM, `ADC_ADDR_PFT};
	logic [7:0]           pf_mode [4] = '{8'h80, 8'h80, 8'hc0, 8'hc0};
	logic [7:0]           pf_thr [4]  = '{8'ha9, 8'haa, 8'haa, 8'ha9};
	logic                 pf_exp [4]  = '{1'b1, 1'b0, 1'b1, 1'b0};
	int                   err_count = 0;
	int                   n_tests   = 0;
	logic [15:0]          rv;
	int                   w;
	int                   c;
	logic                 got;

	always #10 core_clk = ~core_clk;

	adc_pf_ctrl adc_pf_ctrl_i (
		.core_clk            (core_clk),
		.rstn                (rstn),
		.bus_req             (bus_req),
		.bus_ready           (bus_ready),
		.bus_rdata           (bus_rdata),
		.comp_high           (comp_high),
		.dac_code            (dac_code),
		.sample_hold_en      (sample_hold_en),
		.analog_channel      (analog_channel),
		.boost_ref_en        (boost_ref_en),
		.digital_input_en    (digital_input_en),
		.conversion_done_irq (conversion_done_irq)
	);

	analog_front_model analog_front_model_i (
		.level          (level),
		.analog_channel (analog_channel),
		.dac_code       (dac_code),
		.comp_high      (comp_high)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	// request held until ready is seen, released one falling edge after the taking edge
	task automatic access(input logic we, input logic bit_op, input logic [2:0] idx, input logic word,
			input logic [15:0] addr, input logic [7:0] wd);
		@(negedge core_clk);
		bus_req = '{sel: 1'b1, we: we, word: word, bit_op: bit_op, bit_idx: idx, addr: addr, wdata: wd};
		w = 0;
		#1;
		while (bus_ready !== 1'b1 && w < 8) begin
			@(negedge core_clk);
			#1;
			w++;
		end
		rv = bus_rdata;
		if (bus_ready !== 1'b1) begin
			err_count++;
			give_verdict();
		end
		@(negedge core_clk);
		bus_req.sel = 1'b0;
	endtask : access

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		access(1'b1, 1'b0, 3'h0, 1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic word);
		access(1'b0, 1'b0, 3'h0, word, a, 8'h00);
	endtask : rd

	task automatic wait_irq(input int bound);
		got = 1'b0;
		c = 0;
		while (!got && c < bound) begin
			@(negedge core_clk);
			c++;
			got = (conversion_done_irq === 1'b1);
		end
	endtask : wait_irq

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin : main
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		check(conversion_done_irq, 1'b0);
		check(digital_input_en, 4'hf);
		check(boost_ref_en, 1'b0);
		foreach (regs[i]) begin
			rd(regs[i], 1'b0);
			check(rv[7:0], 8'h00);
		end
		rd(16'hff30, 1'b0);
		check(rv[7:0], 8'h00);
		access(1'b1, 1'b1, 3'h0, 1'b0, `ADC_ADDR_MODE, 8'h01);
		check(w, 1);
		check(boost_ref_en, 1'b1);
		access(1'b1, 1'b1, 3'h1, 1'b0, `ADC_ADDR_CHAN, 8'h01);
		check(w, 1);
		check(analog_channel, 2'h2);
		// give the boost reference time to settle before any run
		repeat (700) @(negedge core_clk);
		for (int k = 0; k < 7; k++) begin
			wr(`ADC_ADDR_CHAN, 8'(k % 4));
			// the comparator model settles at once, so the analog time window is not kept at this clock
			wr(`ADC_ADDR_MODE, {2'b10, codes[k], 3'b001});
			check(w, 1);
			check(sample_hold_en, 1'b1);
			check(digital_input_en, 4'hf ^ (4'h1 << (k % 4)));
			wait_irq(700);
			check(got, 1'b1);
			wait_irq(700);
			check(c, cyc[k]);
			rd(`ADC_ADDR_RESULT_LO, 1'b1);
			check(w, 1);
			check(rv, {level[k % 4], 6'h00});
			rd(`ADC_ADDR_RESULT_HI, 1'b0);
			check(rv[7:0], level[k % 4][9:2]);
			rd(`ADC_ADDR_RESULT_LO, 1'b0);
			check(rv[7:0], {level[k % 4][1:0], 6'h00});
			// result already read, and run cleared before the time code changes
			wr(`ADC_ADDR_MODE, 8'h01);
		end
		wr(`ADC_ADDR_CHAN, 8'h00);
		wr(`ADC_ADDR_MODE, 8'hb1);
		for (int k = 0; k < 4; k++) begin
			wr(`ADC_ADDR_PFT, pf_thr[k]);
			wr(`ADC_ADDR_PFM, pf_mode[k]);
			wait_irq(200);
			check(got, pf_exp[k]);
		end
		wr(`ADC_ADDR_PFM, 8'h00);
		wait_irq(200);
		check(got, 1'b1);
		repeat (40) @(negedge core_clk);
		wr(`ADC_ADDR_PFT, 8'h00);
		wait_irq(200);
		check(c > 90 && c < 102, 1'b1);
		repeat (40) @(negedge core_clk);
		wr(`ADC_ADDR_MODE, 8'h31);
		check(digital_input_en, 4'hf);
		check(sample_hold_en, 1'b0);
		wait_irq(200);
		check(got, 1'b0);
		give_verdict();
	end

	initial begin : watchdog
		repeat (100000) @(posedge core_clk);
		err_count++;
		give_verdict();
	end
endmodule : sar_adc_power_fail_control_tb

`default_nettype wire
